// File: addressing_mode_decoder.sv
// Instruction fetch, addressing-mode decode and execute sequencer of an 8-bit core.
// Assumes mem_rdata shows the byte at mem_req.addr in the same cycle.
// Function
// - The core runs a 62-instruction set where each instruction uses one of eight modes.
// - Unsigned multiply puts the high product byte in X and the low byte in A.
// - Inherent instructions are one byte with no operand address and act on core state.
// - Immediate instructions are two bytes, the literal combined with A or X.
// - Direct instructions are two bytes with the operand high address byte zero.
// - Extended instructions are three bytes giving a full address high byte first.
// - Indexed with no offset is one byte and addresses X with a zero high byte.
// - Indexed 8-bit offset is two bytes and adds X and the offset keeping the ninth bit.
// - Indexed 16-bit offset is three bytes and adds X to a high-first 16-bit offset.
// - Relative branches add the sign-extended offset to the next address when taken.
// - Every opcode is classed as register/memory, read-modify-write, jump, bit or control.
// - Register/memory instructions pair A or X with a memory operand at the address.
// - Register/memory provides add, logic, test, compare, load, store, subtract, multiply.
// - Read-modify-write reads a location, modifies it and writes it back to the same place.
// - The negative-or-zero test reads and sets flags but never writes back.
`timescale 1ns/1ps
module addressing_mode_decoder
  import core_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Memory port
  output mem_req_s mem_req,
  input wire logic [7:0] mem_rdata,
  // Core state
  output logic [15:0] pc_q,
  output logic [7:0] acc_q,
  output logic [7:0] idx_q,
  output logic [2:0] nzc_q,
  output dec_s dec_q,
  output logic insn_done_q
);
  // ==========================================================
  // Decode and arithmetic
  function automatic dec_s decode(input logic [7:0] opc);
    dec_s d;
    d.op = opc[3:0];
    d.mode = M_INH;
    d.group = G_CTRL;
    unique case (opc[7:4])
      4'h0: d.group = G_BIT;
      4'h1: begin d.group = G_BIT; d.mode = M_DIR; end
      4'h2: begin d.group = G_JUMP; d.mode = M_REL; end
      4'h3: begin d.group = G_RMW; d.mode = M_DIR; end
      4'h4, 4'h5: d.group = (opc == OPC_MULTIPLY) ? G_REGMEM : G_RMW;
      4'h6: begin d.group = G_RMW; d.mode = M_IX1; end
      4'h7: begin d.group = G_RMW; d.mode = M_IX; end
      4'h8, 4'h9: d.group = G_CTRL;
      default: begin
        d.group = (opc[3:1] == 3'h6) ? G_JUMP : G_REGMEM;
        unique case (opc[7:4])
          4'hA: d.mode = M_IMM;
          4'hB: d.mode = M_DIR;
          4'hC: d.mode = M_EXT;
          4'hD: d.mode = M_IX2;
          4'hE: d.mode = M_IX1;
          default: d.mode = M_IX;
        endcase
      end
    endcase
    return d;
  endfunction : decode

  function automatic alu_s regmem_alu(input logic [3:0] op, input logic [7:0] a,
                                      input logic [7:0] x, input logic [7:0] m,
                                      input logic c);
    alu_s r;
    logic [8:0] s;
    s = {1'b0, a} - {1'b0, m};
    r = '{res: s[7:0], carry: s[8], setc: 1'b1, dst: DST_NONE};
    unique case (op)
      OP_SUB: r.dst = DST_A;
      OP_SBC: begin s = {1'b0, a} - {1'b0, m} - {8'h00, c}; r.res = s[7:0];
        r.carry = s[8]; r.dst = DST_A; end
      OP_CPX: begin s = {1'b0, x} - {1'b0, m}; r.res = s[7:0]; r.carry = s[8]; end
      OP_ADD, OP_ADC: begin s = {1'b0, a} + {1'b0, m} + {8'h00, c & (op == OP_ADC)};
        r.res = s[7:0]; r.carry = s[8]; r.dst = DST_A; end
      OP_CMP: r.setc = 1'b1;
      default: begin
        r.setc = 1'b0;
        unique case (op)
          OP_AND: begin r.res = a & m; r.dst = DST_A; end
          OP_BIT: r.res = a & m;
          OP_LDA: begin r.res = m; r.dst = DST_A; end
          OP_EOR: begin r.res = a ^ m; r.dst = DST_A; end
          OP_ORA: begin r.res = a | m; r.dst = DST_A; end
          OP_LDX: begin r.res = m; r.dst = DST_X; end
          OP_STX: r.res = x;
          default: r.res = a;
        endcase
      end
    endcase
    return r;
  endfunction : regmem_alu

  // dst != DST_NONE means a value to write back
  function automatic alu_s rmw_alu(input logic [3:0] op, input logic [7:0] v,
                                   input logic c);
    alu_s r;
    r = '{res: v, carry: c, setc: 1'b1, dst: DST_A};
    unique case (op)
      OP_NEG: begin r.res = 8'h00 - v; r.carry = (v != 8'h00); end
      OP_COM: begin r.res = ~v; r.carry = 1'b1; end
      OP_LSR: begin r.res = {1'b0, v[7:1]}; r.carry = v[0]; end
      OP_ROR: begin r.res = {c, v[7:1]}; r.carry = v[0]; end
      OP_ASR: begin r.res = {v[7], v[7:1]}; r.carry = v[0]; end
      OP_LSL: begin r.res = {v[6:0], 1'b0}; r.carry = v[7]; end
      OP_ROL: begin r.res = {v[6:0], c}; r.carry = v[7]; end
      OP_DEC: begin r.res = v - 8'h01; r.setc = 1'b0; end
      OP_INC: begin r.res = v + 8'h01; r.setc = 1'b0; end
      OP_TEST_NZ: begin r.setc = 1'b0; r.dst = DST_NONE; end
      OP_CLR: begin r.res = 8'h00; r.carry = 1'b0; end
      default: begin r.setc = 1'b0; r.dst = DST_NONE; end
    endcase
    return r;
  endfunction : rmw_alu

  function automatic logic branch_cond(input logic [3:0] op, input logic [2:0] f);
    logic t;
    unique case (op[3:1])
      3'h0: t = 1'b1;
      3'h1: t = ~(f[0] | f[1]);
      3'h2: t = ~f[0];
      3'h3: t = ~f[1];
      3'h5: t = ~f[2];
      default: t = 1'b0; // Half-carry, mask and pin tests not modelled
    endcase
    return t ^ op[0];
  endfunction : branch_cond

  // ==========================================================
  // Sequencer
  state_e state_q, state_d;
  mem_req_s req_q, req_d;
  logic [15:0] pc_d, ea_n;
  logic [7:0] acc_d, idx_d, opnd_q, opnd_d;
  logic [2:0] nzc_d;
  dec_s dec_d;
  logic done_d, mem_go;
  alu_s r;

  always_comb begin
    state_d = state_q;
    req_d = req_q;
    req_d.we = 1'b0;
    pc_d = pc_q;
    acc_d = acc_q;
    idx_d = idx_q;
    nzc_d = nzc_q;
    dec_d = dec_q;
    opnd_d = opnd_q;
    done_d = 1'b0;
    mem_go = 1'b0;
    ea_n = req_q.addr;
    r = '{res: 8'h00, carry: 1'b0, setc: 1'b0, dst: DST_NONE};
    unique case (state_q)
      S_FETCH: begin
        dec_d = decode(mem_rdata);
        pc_d = pc_q + PC_STEP;
        req_d.addr = pc_d;
        state_d = S_OPER1;
        if (dec_d.mode == M_IX) begin
          ea_n = {BYTE_ZERO, idx_q};
          mem_go = 1'b1;
        end else if (dec_d.mode == M_INH) begin
          state_d = S_FETCH;
          done_d = 1'b1;
          if (mem_rdata == OPC_MULTIPLY) begin
            {idx_d, acc_d} = acc_q * idx_q;
            nzc_d[0] = 1'b0;
          end else if (dec_d.group == G_RMW) begin
            r = rmw_alu(dec_d.op, mem_rdata[4] ? idx_q : acc_q, nzc_q[0]);
            if (r.dst != DST_NONE && mem_rdata[4]) idx_d = r.res;
            if (r.dst != DST_NONE && !mem_rdata[4]) acc_d = r.res;
            nzc_d = {r.res[7], r.res == 8'h00, r.setc ? r.carry : nzc_q[0]};
          end else begin
            unique case (mem_rdata)
              OPC_TAX: idx_d = acc_q;
              OPC_TXA: acc_d = idx_q;
              OPC_CLC: nzc_d[0] = 1'b0;
              OPC_SEC: nzc_d[0] = 1'b1;
              default: ;
            endcase
          end
        end
      end
      S_OPER1: begin
        opnd_d = mem_rdata;
        pc_d = pc_q + PC_STEP;
        req_d.addr = pc_d;
        state_d = S_FETCH;
        unique case (dec_q.mode)
          M_IMM: begin
            done_d = 1'b1;
            r = regmem_alu(dec_q.op, acc_q, idx_q, mem_rdata, nzc_q[0]);
          end
          M_DIR: begin ea_n = {BYTE_ZERO, mem_rdata}; mem_go = 1'b1; end
          M_IX1: begin
            ea_n = {7'h00, {1'b0, idx_q} + {1'b0, mem_rdata}};
            mem_go = 1'b1;
          end
          M_REL: begin
            done_d = 1'b1;
            if (branch_cond(dec_q.op, nzc_q)) begin
              pc_d = pc_q + PC_STEP + {{8{mem_rdata[7]}}, mem_rdata};
            end
            req_d.addr = pc_d;
          end
          default: state_d = S_OPER2;
        endcase
      end
      S_OPER2: begin
        pc_d = pc_q + PC_STEP;
        req_d.addr = pc_d;
        ea_n = {opnd_q, mem_rdata};
        if (dec_q.mode == M_IX2) ea_n = {opnd_q, mem_rdata} + {BYTE_ZERO, idx_q};
        mem_go = 1'b1;
      end
      S_READ: begin
        state_d = S_FETCH;
        req_d.addr = pc_q;
        done_d = 1'b1;
        if (dec_q.group == G_REGMEM) begin
          r = regmem_alu(dec_q.op, acc_q, idx_q, mem_rdata, nzc_q[0]);
        end else begin
          r = rmw_alu(dec_q.op, mem_rdata, nzc_q[0]);
          if (dec_q.group == G_BIT) begin
            r.res = mem_rdata;
            r.res[dec_q.op[3:1]] = ~dec_q.op[0];
            r.setc = 1'b0;
            r.dst = DST_A;
          end
          if (r.dst != DST_NONE) begin
            state_d = S_WRITE;
            req_d = '{addr: req_q.addr, wdata: r.res, we: 1'b1};
            done_d = 1'b0;
          end
          r.dst = DST_NONE;
        end
      end
      S_WRITE: begin
        state_d = S_FETCH;
        req_d.addr = pc_q;
        done_d = 1'b1;
      end
      default: state_d = S_FETCH;
    endcase
    if (state_q inside {S_OPER1, S_READ} && dec_q.mode != M_REL && dec_q.group != G_BIT) begin
      if (r.dst == DST_A) acc_d = r.res;
      if (r.dst == DST_X) idx_d = r.res;
      if (done_d) nzc_d = {r.res[7], r.res == 8'h00, r.setc ? r.carry : nzc_q[0]};
    end
    // Stores skip the read so that write-only locations are never sampled
    if (mem_go) begin
      req_d.addr = ea_n;
      state_d = S_READ;
      if (dec_d.group == G_REGMEM && dec_d.op inside {OP_STA, OP_STX}) begin
        state_d = S_WRITE;
        req_d.we = 1'b1;
        req_d.wdata = dec_d.op[3] ? idx_q : acc_q;
        nzc_d[2:1] = {req_d.wdata[7], req_d.wdata == 8'h00};
      end else if (dec_d.group == G_JUMP) begin
        state_d = S_FETCH;
        done_d = 1'b1;
        if (dec_d.op == OP_JMP) pc_d = ea_n;
        req_d.addr = pc_d;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_FETCH;
      req_q <= '{addr: PC_RESET, wdata: 8'h00, we: 1'b0};
      pc_q <= PC_RESET;
      acc_q <= 8'h00;
      idx_q <= 8'h00;
      nzc_q <= 3'h0;
      dec_q <= '{group: G_CTRL, mode: M_INH, op: 4'h0};
      opnd_q <= 8'h00;
      insn_done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      pc_q <= pc_d;
      acc_q <= acc_d;
      idx_q <= idx_d;
      nzc_q <= nzc_d;
      dec_q <= dec_d;
      opnd_q <= opnd_d;
      insn_done_q <= done_d;
    end
  end

  assign mem_req = req_q;

  // ==========================================================
  // Checks
  property p_multiply;
    @(posedge clk) disable iff (!reset_n)
      (state_q == S_FETCH && mem_rdata == OPC_MULTIPLY) |=>
        ({idx_q, acc_q} == $past(acc_q) * $past(idx_q));
  endproperty
  a_multiply: assert property (p_multiply) else $error("multiply product misplaced");
  property p_inh;
    @(posedge clk) disable iff (!reset_n)
      (state_q == S_FETCH && dec_d.mode == M_INH) |=>
        (state_q == S_FETCH && pc_q == $past(pc_q) + 16'h0001 && insn_done_q);
  endproperty
  a_inh: assert property (p_inh) else $error("inherent length wrong");
  property p_imm;
    @(posedge clk) disable iff (!reset_n)
      (state_q == S_FETCH && dec_d.mode == M_IMM) |=>
        (state_q == S_OPER1) ##1 (state_q == S_FETCH && pc_q == $past(pc_q, 2) + 16'h0002);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate length wrong");
  property p_dir;
    @(posedge clk) disable iff (!reset_n)
      (state_q == S_OPER1 && dec_q.mode == M_DIR) |=> (mem_req.addr == {8'h00, $past(mem_rdata)});
  endproperty
  a_dir: assert property (p_dir) else $error("direct address wrong");
  property p_ext;
    @(posedge clk) disable iff (!reset_n)
      (state_q == S_OPER2 && dec_q.mode == M_EXT) |=>
        (mem_req.addr == {$past(opnd_q), $past(mem_rdata)});
  endproperty
  a_ext: assert property (p_ext) else $error("extended address wrong");
  property p_ix;
    @(posedge clk) disable iff (!reset_n)
      (state_q == S_FETCH && dec_d.mode == M_IX) |=>
        (mem_req.addr == {8'h00, $past(idx_q)} && state_q != S_OPER1);
  endproperty
  a_ix: assert property (p_ix) else $error("indexed address wrong");
  property p_ix1;
    @(posedge clk) disable iff (!reset_n)
      (state_q == S_OPER1 && dec_q.mode == M_IX1) |=>
        (mem_req.addr == 16'($past(idx_q)) + 16'($past(mem_rdata)));
  endproperty
  a_ix1: assert property (p_ix1) else $error("8-bit offset address wrong");
  property p_ix2;
    @(posedge clk) disable iff (!reset_n)
      (state_q == S_OPER2 && dec_q.mode == M_IX2) |=>
        (mem_req.addr == 16'({$past(opnd_q), $past(mem_rdata)} + 16'($past(idx_q))));
  endproperty
  a_ix2: assert property (p_ix2) else $error("16-bit offset address wrong");
  property p_bra;
    @(posedge clk) disable iff (!reset_n)
      (state_q == S_OPER1 && dec_q.mode == M_REL && dec_q.op == 4'h0) |=>
        (pc_q == 16'($past(pc_q) + 16'h0001 + {{8{$past(mem_rdata[7])}}, $past(mem_rdata)}));
  endproperty
  a_bra: assert property (p_bra) else $error("branch target wrong");
  property p_test_nz;
    @(posedge clk) disable iff (!reset_n)
      (state_q == S_READ && dec_q.group == G_RMW && dec_q.op == OP_TEST_NZ) |=>
        (!mem_req.we && state_q == S_FETCH);
  endproperty
  a_test_nz: assert property (p_test_nz) else $error("test wrote back");
  property p_rmw;
    @(posedge clk) disable iff (!reset_n)
      (state_q == S_READ && dec_q.group == G_RMW && dec_q.op == OP_INC) |=>
        (mem_req.we && mem_req.addr == $past(mem_req.addr)
         && mem_req.wdata == 8'($past(mem_rdata) + 8'h01)) ##1 (state_q == S_FETCH);
  endproperty
  a_rmw: assert property (p_rmw) else $error("write-back wrong");
endmodule : addressing_mode_decoder

// File: core_pkg.sv
// Shared types and constants for the 8-bit core decoder/sequencer.
// Assumes one clock domain and a memory answering from a registered address.
package core_pkg;
  // ==========================================================
  // Sequencer states, modes and groups
  typedef enum logic [2:0] {S_FETCH, S_OPER1, S_OPER2, S_READ, S_WRITE} state_e;
  typedef enum logic [2:0] {M_INH, M_IMM, M_DIR, M_EXT, M_IX, M_IX1, M_IX2, M_REL} mode_e;
  typedef enum logic [2:0] {G_REGMEM, G_RMW, G_JUMP, G_BIT, G_CTRL} group_e;
  typedef struct packed {group_e group; mode_e mode; logic [3:0] op;} dec_s;
  typedef struct packed {logic [15:0] addr; logic [7:0] wdata; logic we;} mem_req_s;
  typedef struct packed {logic [7:0] res; logic carry; logic setc; logic [1:0] dst;} alu_s;
  // ==========================================================
  // Counts and reset values
  localparam int INSN_COUNT = 62;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [1:0] DST_NONE = 2'h0;
  localparam logic [1:0] DST_A = 2'h1;
  localparam logic [1:0] DST_X = 2'h2;
  // ==========================================================
  // Opcodes and low-nibble operations
  localparam logic [7:0] OPC_MULTIPLY = 8'h42;
  localparam logic [7:0] OPC_TAX = 8'h97;
  localparam logic [7:0] OPC_CLC = 8'h98;
  localparam logic [7:0] OPC_SEC = 8'h99;
  localparam logic [7:0] OPC_TXA = 8'h9F;
  localparam logic [3:0] OP_SUB = 4'h0, OP_CMP = 4'h1, OP_SBC = 4'h2, OP_CPX = 4'h3;
  localparam logic [3:0] OP_AND = 4'h4, OP_BIT = 4'h5, OP_LDA = 4'h6, OP_STA = 4'h7;
  localparam logic [3:0] OP_EOR = 4'h8, OP_ADC = 4'h9, OP_ORA = 4'hA, OP_ADD = 4'hB;
  localparam logic [3:0] OP_JMP = 4'hC, OP_JSR = 4'hD, OP_LDX = 4'hE, OP_STX = 4'hF;
  localparam logic [3:0] OP_NEG = 4'h0, OP_COM = 4'h3, OP_LSR = 4'h4, OP_ROR = 4'h6;
  localparam logic [3:0] OP_ASR = 4'h7, OP_LSL = 4'h8, OP_ROL = 4'h9, OP_DEC = 4'hA;
  localparam logic [3:0] OP_INC = 4'hC, OP_TEST_NZ = 4'hD, OP_CLR = 4'hF;
endpackage : core_pkg

// File: program_memory.sv
// Zero-wait behavioural memory for the core's memory port.
// Assumes the bench preloads programs straight into the mem array.
`timescale 1ns/1ps
module program_memory
  import core_pkg::*;
(
  // Clock
  input wire logic clk,
  // Memory port
  input wire mem_req_s mem_req,
  output logic [7:0] mem_rdata
);
  // ==========================================================
  // Storage
  logic [7:0] mem [0:65535];

  // Combinational read, so no wait state can hide an address slip
  assign mem_rdata = mem[mem_req.addr];

  always @(posedge clk) begin
    if (mem_req.we === 1'b1) begin
      mem[mem_req.addr] <= mem_req.wdata;
    end
  end
endmodule : program_memory

// File: addressing_mode_decoder_tb.sv
// Self-checking bench: runs short programs and checks core state and memory.
// Assumes the core fetches from address 0000 right after reset release.
`timescale 1ns/1ps
module addressing_mode_decoder_tb
  import core_pkg::*;
;
  // ==========================================================
  // Signals
  logic clk;
  logic reset_n;
  mem_req_s mem_req;
  logic [7:0] mem_rdata;
  logic [15:0] pc_q;
  logic [7:0] acc_q;
  logic [7:0] idx_q;
  logic [2:0] nzc_q;
  dec_s dec_q;
  logic insn_done_q;
  int num_errors;
  int n_checks;
  int n_writes;
  logic [15:0] pa;

  addressing_mode_decoder addressing_mode_decoder_i (
    .clk(clk), .reset_n(reset_n), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .pc_q(pc_q), .acc_q(acc_q), .idx_q(idx_q), .nzc_q(nzc_q), .dec_q(dec_q),
    .insn_done_q(insn_done_q)
  );

  program_memory program_memory_i (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  always #10 clk = ~clk;

  always @(posedge clk) begin
    if (mem_req.we === 1'b1) n_writes++;
  end

  // ==========================================================
  // Helpers
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // Reset held and memory filled with one-byte no-ops
  task start;
    @(negedge clk);
    reset_n = 1'b0;
    for (int i = 0; i < 65536; i++) program_memory_i.mem[i] = 8'h9D;
    pa = 16'h0000;
    repeat (20) @(negedge clk);
  endtask : start

  task go;
    reset_n = 1'b1;
  endtask : go

  task emit(input int n, input logic [7:0] b0, input logic [7:0] b1 = 8'h00,
            input logic [7:0] b2 = 8'h00);
    program_memory_i.mem[pa] = b0;
    program_memory_i.mem[pa + 16'h0001] = (n > 1) ? b1 : 8'h9D;
    program_memory_i.mem[pa + 16'h0002] = (n > 2) ? b2 : 8'h9D;
    pa = pa + n[15:0];
  endtask : emit

  // Bounded wait for n completion pulses
  task step(input int n);
    int seen;
    int waited;
    seen = 0;
    waited = 0;
    while (seen < n && waited < 100 * n) begin
      @(negedge clk);
      waited++;
      if (insn_done_q === 1'b1) seen++;
    end
    check(seen[15:0], n[15:0]);
  endtask : step

  function automatic logic [7:0] alu_ref(input logic [3:0] op, input logic [7:0] a,
                                         input logic [7:0] m, input logic c);
    case (op)
      OP_SUB: return a - m;
      OP_SBC: return a - m - {7'h00, c};
      OP_AND: return a & m;
      OP_EOR: return a ^ m;
      OP_ADC: return a + m + {7'h00, c};
      OP_ORA: return a | m;
      OP_ADD: return a + m;
      OP_LDA: return m;
      default: return a;
    endcase
  endfunction : alu_ref

  // ==========================================================
  // Scenarios
  task t_multiply;
    start;
    emit(2, 8'hA6, 8'h12);
    emit(2, 8'hAE, 8'h34);
    emit(1, OPC_MULTIPLY);
    emit(2, 8'hA6, 8'hFF);
    emit(2, 8'hAE, 8'hFF);
    emit(1, OPC_SEC);
    emit(1, OPC_MULTIPLY);
    go;
    step(3);
    check(acc_q, 16'h00A8);
    check(idx_q, 16'h0003);
    check(pc_q, 16'h0005);
    step(4);
    check({idx_q, acc_q}, 16'hFE01);
    check(nzc_q[0], 16'h0000);
  endtask : t_multiply

  task t_direct_extended;
    int w;
    start;
    program_memory_i.mem[16'h1234] = 8'h5A;
    program_memory_i.mem[16'h0081] = 8'h77;
    program_memory_i.mem[16'h0181] = 8'hFF;
    emit(3, 8'hC6, 8'h12, 8'h34);
    emit(2, 8'hB7, 8'h80);
    emit(2, 8'hB6, 8'h81);
    emit(2, 8'hAE, 8'h9C);
    emit(3, 8'hCF, 8'h12, 8'h35);
    go;
    step(1);
    check(acc_q, 16'h005A);
    check(pc_q, 16'h0003);
    w = n_writes;
    step(1);
    check(program_memory_i.mem[16'h0080], 16'h005A);
    check(n_writes - w, 16'h0001);
    step(1);
    check(acc_q, 16'h0077);
    check(pc_q, 16'h0007);
    step(2);
    check(program_memory_i.mem[16'h1235], 16'h009C);
  endtask : t_direct_extended

  task t_indexed;
    start;
    program_memory_i.mem[16'h00FF] = 8'h11;
    program_memory_i.mem[16'h01FE] = 8'h22;
    program_memory_i.mem[16'h00FE] = 8'hEE;
    program_memory_i.mem[16'h001F] = 8'h33;
    emit(2, 8'hAE, 8'hFF);
    emit(1, 8'hF6);
    emit(2, 8'hE6, 8'hFF);
    emit(3, 8'hD6, 8'hFF, 8'h20);
    emit(2, 8'hA3, 8'hFF);
    go;
    step(2);
    check(acc_q, 16'h0011);
    check(pc_q, 16'h0003);
    step(1);
    check(acc_q, 16'h0022);
    check(pc_q, 16'h0005);
    step(1);
    check(acc_q, 16'h0033);
    check(pc_q, 16'h0008);
    check(16'(dec_q.mode), 16'(M_IX2));
    step(1);
    check(nzc_q[1:0], 16'h0002);
  endtask : t_indexed

  task t_branch;
    logic [15:0] exp [8];
    exp = '{16'h0080, 16'h0002, 16'h0004, 16'h0005, 16'h0017, 16'h0019, 16'hFFF0, 16'h0012};
    start;
    emit(2, 8'h20, 8'h7E);
    emit(2, 8'h21, 8'h55);
    emit(1, OPC_SEC);
    emit(2, 8'h25, 8'h10);
    pa = 16'h0080;
    emit(2, 8'h20, 8'h80);
    pa = 16'h0017;
    emit(2, 8'h24, 8'h10);
    emit(3, 8'hCC, 8'hFF, 8'hF0);
    pa = 16'hFFF0;
    emit(2, 8'h20, 8'h20);
    go;
    for (int k = 0; k < 8; k++) begin
      step(1);
      check(pc_q, exp[k]);
    end
  endtask : t_branch

  task t_rmw;
    int w;
    start;
    program_memory_i.mem[16'h0040] = 8'h7F;
    program_memory_i.mem[16'h0041] = 8'h00;
    emit(2, 8'hAE, 8'h40);
    emit(1, 8'h7C);
    emit(1, 8'h7D);
    emit(2, 8'h3A, 8'h41);
    emit(1, 8'h4C);
    go;
    step(1);
    w = n_writes;
    step(1);
    check(program_memory_i.mem[16'h0040], 16'h0080);
    check(n_writes - w, 16'h0001);
    step(1);
    check(n_writes - w, 16'h0001);
    check(nzc_q[2:1], 16'h0002);
    check(16'(dec_q.group), 16'(G_RMW));
    step(1);
    check(program_memory_i.mem[16'h0041], 16'h00FF);
    step(1);
    check(acc_q, 16'h0001);
  endtask : t_rmw

  // Immediate forms of every accumulator operation except store, carry alternating
  task t_regmem_ops;
    logic [3:0] ops [10];
    ops = '{OP_SUB, OP_CMP, OP_SBC, OP_AND, OP_BIT, OP_LDA, OP_EOR, OP_ADC, OP_ORA, OP_ADD};
    for (int k = 0; k < 10; k++) begin
      start;
      emit(2, 8'hA6, 8'h5C);
      emit(1, k[0] ? OPC_SEC : OPC_CLC);
      emit(2, {4'hA, ops[k]}, 8'h27);
      go;
      step(3);
      check(acc_q, alu_ref(ops[k], 8'h5C, 8'h27, k[0]));
    end
  endtask : t_regmem_ops

  // ==========================================================
  // Verdict and run control
  task tally_and_finish;
    $display("Checks made: %0d, mismatches: %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Generous over the few hundred cycles the programs need
  initial begin
    #(20 * 5000);
    num_errors++;
    tally_and_finish;
  end

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    num_errors = 0;
    n_checks = 0;
    n_writes = 0;
    pa = 16'h0000;
    t_multiply;
    t_direct_extended;
    t_indexed;
    t_branch;
    t_rmw;
    t_regmem_ops;
    tally_and_finish;
  end
endmodule : addressing_mode_decoder_tb
